// File: common/sfci_regs.vh
// Register map, field layout and timing constants of the status indicator block
`ifndef SFCI_REGS_VH
`define SFCI_REGS_VH
`define SFCI_CLK_HZ 40000000
`define SFCI_CHECK_RATE_HZ 100
`define SFCI_CHECK_CYC (`SFCI_CLK_HZ / `SFCI_CHECK_RATE_HZ)
`define SFCI_POWERUP_MS 500
`define SFCI_POWERUP_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_POWERUP_MS)
`define SFCI_SLOW_HALF_MS 500
`define SFCI_SLOW_HALF_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_SLOW_HALF_MS)
`define SFCI_FAST_HALF_MS 100
`define SFCI_FAST_HALF_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_FAST_HALF_MS)
`define SFCI_PAUSE_MS 2000
`define SFCI_PAUSE_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_PAUSE_MS)
`define SFCI_SLEEP_PERIOD_MS 3500
`define SFCI_SLEEP_PERIOD_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_SLEEP_PERIOD_MS)
`define SFCI_SLEEP_ON_MS 200
`define SFCI_SLEEP_ON_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_SLEEP_ON_MS)
`define SFCI_BRAKE_MS 2000
`define SFCI_BRAKE_CYC (`SFCI_CLK_HZ / 1000 * `SFCI_BRAKE_MS)
`define SFCI_CTRL_OFF 12'h000
`define SFCI_STAT_OFF 12'h004
`define SFCI_TRIP_OFF 12'h008
`define SFCI_CTRL_RST 32'h0000_0000
`define SFCI_CTRL_CODED_BIT 0
`define SFCI_CTRL_SLEEP_BIT 1
`define SFCI_STAT_DRIVE_BIT 0
`define SFCI_STAT_TRIP_BIT 1
`define SFCI_STAT_HELD_BIT 2
`define SFCI_STAT_SLEEP_BIT 3
`define SFCI_STAT_READY_BIT 4
`define SFCI_STAT_BRAKE_BIT 5
`define SFCI_STAT_LAMP_BIT 6
`define SFCI_STAT_CODE_LSB 8
`define SFCI_TRIP_CODE_LSB 0
`define SFCI_TRIP_SET_BIT 8
`define SFCI_CODE_LOWBAT 4'h1
`define SFCI_CODE_MOTOR 4'h2
`define SFCI_CODE_SHORT 4'h3
`define SFCI_CODE_INHIBIT 4'h6
`define SFCI_CODE_THROTTLE 4'h7
`define SFCI_CODE_INTERNAL 4'h8
`define SFCI_CODE_BRAKE 4'h9
`define SFCI_CODE_OVERVOLT 4'ha
`endif

// File: rtl/sfci_pattern.v
// Lamp pattern generator: steady, slow, coded, sleep blink, rapid
`timescale 1ns/1ps
`include "sfci_regs.vh"
module sfci_pattern #(
  parameter SLOW_HALF = `SFCI_SLOW_HALF_CYC,
  parameter FAST_HALF = `SFCI_FAST_HALF_CYC,
  parameter PAUSE = `SFCI_PAUSE_CYC,
  parameter SLEEP_PERIOD = `SFCI_SLEEP_PERIOD_CYC,
  parameter SLEEP_ON = `SFCI_SLEEP_ON_CYC
) (
  input wire clk,
  input wire nrst,
  input wire [2:0] mode,
  input wire [3:0] code,
  output reg lamp_q
);
  localparam M_OFF = 3'd0;
  localparam M_STEADY = 3'd1;
  localparam M_SLOW = 3'd2;
  localparam M_CODED = 3'd3;
  localparam M_RAPID = 3'd4;
  localparam M_SLEEP = 3'd5;
  reg [31:0] tmr_q;
  reg [3:0] cnt_q;
  reg ph_q;
  reg [2:0] mode_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_q <= 32'h0000_0000;
      cnt_q <= 4'h0;
      ph_q <= 1'b0;
      mode_q <= 3'd0;
      lamp_q <= 1'b0;
    end else begin
      mode_q <= mode;
      if (mode != mode_q) begin
        // Restart so a new pattern opens with a full first flash
        tmr_q <= 32'h0000_0000;
        cnt_q <= 4'h0;
        ph_q <= 1'b1;
        lamp_q <= (mode != M_OFF) && (mode != M_SLEEP);
      end else begin
        tmr_q <= tmr_q + 32'h0000_0001;
        case (mode)
          M_STEADY: begin
            lamp_q <= 1'b1;
          end
          M_SLOW: begin
            if (tmr_q >= SLOW_HALF - 1) begin
              tmr_q <= 32'h0000_0000;
              ph_q <= ~ph_q;
            end
            lamp_q <= ph_q;
          end
          M_RAPID: begin
            if (tmr_q >= FAST_HALF - 1) begin
              tmr_q <= 32'h0000_0000;
              ph_q <= ~ph_q;
            end
            lamp_q <= ph_q;
          end
          M_CODED: begin
            // code flashes, then one long pause
            if (cnt_q >= code) begin
              lamp_q <= 1'b0;
              if (tmr_q >= PAUSE - 1) begin
                tmr_q <= 32'h0000_0000;
                cnt_q <= 4'h0;
                ph_q <= 1'b1;
              end
            end else begin
              lamp_q <= ph_q;
              if (tmr_q >= SLOW_HALF - 1) begin
                tmr_q <= 32'h0000_0000;
                ph_q <= ~ph_q;
                if (!ph_q) begin
                  cnt_q <= cnt_q + 4'h1;
                end
              end
            end
          end
          M_SLEEP: begin
            if (tmr_q >= SLEEP_PERIOD - 1) begin
              tmr_q <= 32'h0000_0000;
            end
            lamp_q <= (tmr_q < SLEEP_ON);
          end
          default: begin
            lamp_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sfci_pattern

// File: rtl/sfci_sync.v
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module sfci_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] level_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Only accept a change once two later stages agree
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          level_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // sfci_sync

// File: rtl/sfci_top.v
// Status flash-code indicator with drive inhibit and APB register access
// Overview of operation
// - Safety check pulse repeats at most 100 times per second.
// - Throttle held at power-on stops motor and shows seven-flash code.
// - Throttle seen in first half second blocks drive until power cycle.
// - After check interval, healthy unit shows steady or slow flash.
// - Throttle back at rest engages parking brake within seconds, both directions.
// - No fault and good battery keeps lamp steadily lit.
// - Below either low-battery threshold: slow continuous flash, drive allowed.
// - Coded trip setting repeats N slow flashes then pause.
// - Any trip blocks drive until power is cycled.
// - Uncoded trip flashes rapidly and continuously.
// - Sleep blinks briefly every 3.5 s, left only by power cycle.
// - Bar gauge shows red-yellow-green, red-yellow or red by charge.
// - Codes 1-3: low battery, motor connection, motor short.
// - Codes 4-5 unused, 6 drive inhibit, 7 throttle fault.
// - Code 8 internal fault, 9 brake connection, 10 overvoltage.
`timescale 1ns/1ps
`include "sfci_regs.vh"
module sfci_top #(
  parameter POWERUP_CYC = `SFCI_POWERUP_CYC,
  parameter CHECK_CYC = `SFCI_CHECK_CYC,
  parameter BRAKE_CYC = `SFCI_BRAKE_CYC,
  parameter SLOW_HALF = `SFCI_SLOW_HALF_CYC,
  parameter FAST_HALF = `SFCI_FAST_HALF_CYC,
  parameter PAUSE = `SFCI_PAUSE_CYC,
  parameter SLEEP_PERIOD = `SFCI_SLEEP_PERIOD_CYC,
  parameter SLEEP_ON = `SFCI_SLEEP_ON_CYC
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire throttle_active,
  input wire fault_low_batt_conn,
  input wire fault_motor_conn,
  input wire fault_motor_short,
  input wire fault_inhibit,
  input wire fault_throttle,
  input wire fault_internal,
  input wire fault_brake_conn,
  input wire fault_overvolt,
  input wire batt_low1,
  input wire batt_low2,
  input wire [1:0] charge_level,
  output reg drive_enable_q,
  output reg brake_engage_q,
  output reg check_tick_q,
  output wire lamp,
  output reg [2:0] bar_gauge_display_q
);
  localparam ST_CHECK = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_TRIP = 2'd2;
  localparam ST_SLEEP = 2'd3;
  localparam M_OFF = 3'd0;
  localparam M_STEADY = 3'd1;
  localparam M_SLOW = 3'd2;
  localparam M_CODED = 3'd3;
  localparam M_RAPID = 3'd4;
  localparam M_SLEEP = 3'd5;
  localparam NIN = 13;

  wire [NIN-1:0] pins_s;
  sfci_sync #(.W(NIN)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in({charge_level, batt_low2, batt_low1, fault_overvolt, fault_brake_conn,
      fault_internal, fault_throttle, fault_inhibit, fault_motor_short,
      fault_motor_conn, fault_low_batt_conn, throttle_active}),
    .level_q(pins_s)
  );
  wire thr_s = pins_s[0];
  wire [7:0] flt_s = pins_s[8:1];
  wire low_s = pins_s[9] | pins_s[10];
  wire [1:0] chg_s = pins_s[12:11];

  reg [1:0] st_q;
  reg [31:0] tmr_q;
  reg [31:0] chk_q;
  reg [31:0] brk_q;
  reg [3:0] code_q;
  reg held_q;
  reg [31:0] ctrl_q;
  reg sw_sleep_q;

  // Priority encoder of live faults into the numbered trip codes
  reg [3:0] fcode;
  always @* begin
    fcode = 4'h0;
    if (flt_s[7]) fcode = `SFCI_CODE_OVERVOLT;
    if (flt_s[6]) fcode = `SFCI_CODE_BRAKE;
    if (flt_s[5]) fcode = `SFCI_CODE_INTERNAL;
    if (flt_s[4]) fcode = `SFCI_CODE_THROTTLE;
    if (flt_s[3]) fcode = `SFCI_CODE_INHIBIT;
    if (flt_s[2]) fcode = `SFCI_CODE_SHORT;
    if (flt_s[1]) fcode = `SFCI_CODE_MOTOR;
    if (flt_s[0]) fcode = `SFCI_CODE_LOWBAT;
  end

  // Safety checks run on a fixed tick, never faster than the rate ceiling
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_q <= 32'h0000_0000;
      check_tick_q <= 1'b0;
    end else if (chk_q >= CHECK_CYC - 1) begin
      chk_q <= 32'h0000_0000;
      check_tick_q <= 1'b1;
    end else begin
      chk_q <= chk_q + 32'h0000_0001;
      check_tick_q <= 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_CHECK;
      tmr_q <= 32'h0000_0000;
      code_q <= 4'h0;
      held_q <= 1'b0;
      sw_sleep_q <= 1'b0;
    end else begin
      case (st_q)
        ST_CHECK: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (thr_s) begin
            held_q <= 1'b1;
          end
          if (tmr_q >= POWERUP_CYC - 1) begin
            if (held_q || thr_s) begin
              st_q <= ST_TRIP;
              code_q <= `SFCI_CODE_THROTTLE;
            end else if (fcode != 4'h0) begin
              st_q <= ST_TRIP;
              code_q <= fcode;
            end else begin
              st_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (check_tick_q && fcode != 4'h0) begin
            st_q <= ST_TRIP;
            code_q <= fcode;
          end else if (sw_sleep_q) begin
            st_q <= ST_SLEEP;
          end
        end
        // Trip and sleep are left only through reset, i.e. power cycle
        ST_TRIP: begin
          st_q <= ST_TRIP;
        end
        ST_SLEEP: begin
          st_q <= ST_SLEEP;
        end
        default: begin
          st_q <= ST_TRIP;
          code_q <= `SFCI_CODE_INTERNAL;
        end
      endcase
      if (psel && penable && pwrite && paddr == `SFCI_CTRL_OFF
          && pwdata[`SFCI_CTRL_SLEEP_BIT]) begin
        sw_sleep_q <= 1'b1;
      end
    end
  end

  // Drive and parking brake
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive_enable_q <= 1'b0;
      brake_engage_q <= 1'b1;
      brk_q <= 32'h0000_0000;
    end else begin
      drive_enable_q <= (st_q == ST_RUN) && thr_s;
      if (st_q != ST_RUN || thr_s) begin
        brk_q <= 32'h0000_0000;
        brake_engage_q <= (st_q != ST_RUN);
      end else if (brk_q >= BRAKE_CYC - 1) begin
        brake_engage_q <= 1'b1;
      end else begin
        brk_q <= brk_q + 32'h0000_0001;
      end
    end
  end

  // Pattern selection
  reg [2:0] mode;
  always @* begin
    case (st_q)
      ST_CHECK: mode = M_STEADY;
      ST_RUN: mode = low_s ? M_SLOW : M_STEADY;
      ST_TRIP: mode = ctrl_q[`SFCI_CTRL_CODED_BIT] ? M_CODED : M_RAPID;
      ST_SLEEP: mode = M_SLEEP;
      default: mode = M_OFF;
    endcase
  end

  sfci_pattern #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF),
    .PAUSE(PAUSE),
    .SLEEP_PERIOD(SLEEP_PERIOD),
    .SLEEP_ON(SLEEP_ON)
  ) u_pat (
    .clk(clk),
    .nrst(nrst),
    .mode(mode),
    .code(code_q),
    .lamp_q(lamp)
  );

  // Bar gauge: {green, yellow, red}; flashing modes drive the red bar only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bar_gauge_display_q <= 3'b000;
    end else if (mode == M_STEADY && st_q == ST_RUN) begin
      case (chg_s)
        2'd2, 2'd3: bar_gauge_display_q <= 3'b111;
        2'd1: bar_gauge_display_q <= 3'b011;
        default: bar_gauge_display_q <= 3'b001;
      endcase
    end else begin
      bar_gauge_display_q <= {2'b00, lamp};
    end
  end

  // APB slave, zero wait states
  assign pready = 1'b1;
  wire wr = psel && penable && pwrite;
  wire hit = (paddr == `SFCI_CTRL_OFF) || (paddr == `SFCI_STAT_OFF)
    || (paddr == `SFCI_TRIP_OFF);
  assign pslverr = psel && penable && !hit;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `SFCI_CTRL_RST;
    end else if (wr && paddr == `SFCI_CTRL_OFF) begin
      ctrl_q <= {30'h0, pwdata[1:0]};
    end
  end
  always @* begin
    case (paddr)
      `SFCI_CTRL_OFF: prdata = ctrl_q;
      `SFCI_STAT_OFF: prdata = {20'h0, code_q, 1'b0, lamp, brake_engage_q,
        st_q == ST_RUN, st_q == ST_SLEEP, held_q, st_q == ST_TRIP, drive_enable_q};
      `SFCI_TRIP_OFF: prdata = {23'h0, st_q == ST_TRIP, 4'h0, code_q};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule // sfci_top

// File: testbench/sfci_checker.sv
// Port-level assertions of the indicator block
`timescale 1ns/1ps
`include "sfci_regs.vh"
module sfci_checker #(
  parameter int POWERUP_CYC = 50,
  parameter int CHECK_CYC = 10
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire throttle_active,
  input wire fault_inhibit,
  input wire drive_enable_q,
  input wire brake_engage_q,
  input wire check_tick_q,
  input wire [2:0] bar_gauge_display_q
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  // Window suits the shortened brake count only
  localparam int BRK_WIN = 48;
  int tick_n_q;
  int up_n_q;
  int flt_n_q;
  logic seen_q;
  logic trip_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_n_q <= 0;
      up_n_q <= 0;
      flt_n_q <= 0;
      seen_q <= 1'h0;
      trip_q <= 1'h0;
    end else begin
      tick_n_q <= check_tick_q ? 0 : tick_n_q + 1;
      seen_q <= seen_q | check_tick_q;
      up_n_q <= (up_n_q < POWERUP_CYC + 8) ? up_n_q + 1 : up_n_q;
      flt_n_q <= !fault_inhibit ? 0 : (flt_n_q < 30) ? flt_n_q + 1 : flt_n_q;
      // A fault held this long after power-up must have tripped
      if (up_n_q >= POWERUP_CYC + 8 && flt_n_q >= 24) trip_q <= 1'h1;
    end
  end
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !(paddr inside
    {`SFCI_CTRL_OFF, `SFCI_STAT_OFF, `SFCI_TRIP_OFF})) else $error("pslverr wrong");
  a_tick_min: assert property (seen_q && check_tick_q |-> tick_n_q >= CHECK_CYC - 1)
    else $error("check tick early");
  a_tick_max: assert property (seen_q |-> tick_n_q < CHECK_CYC)
    else $error("check tick late");
  a_drive_idle: assert property ((!throttle_active) [*6] |=> !drive_enable_q)
    else $error("drive without throttle");
  a_brake_after: assert property ($fell(drive_enable_q) |-> ##[0:BRK_WIN] brake_engage_q)
    else $error("brake not engaged");
  a_trip_nodrive: assert property (trip_q |-> !drive_enable_q)
    else $error("drive after trip");
  a_bar_order: assert property (bar_gauge_display_q[2:1] != 2'h2 &&
    bar_gauge_display_q[1:0] != 2'h2) else $error("bar order wrong");
endmodule // sfci_checker
bind sfci_top sfci_checker #(.POWERUP_CYC(POWERUP_CYC), .CHECK_CYC(CHECK_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .throttle_active(throttle_active), .fault_inhibit(fault_inhibit),
  .drive_enable_q(drive_enable_q), .brake_engage_q(brake_engage_q),
  .check_tick_q(check_tick_q), .bar_gauge_display_q(bar_gauge_display_q));

// File: testbench/sfci_top_tb.sv
// Self-checking bench of the status indicator block
`timescale 1ns/1ps
`include "sfci_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module sfci_top_tb;
  localparam int PU = 50, SH = 8, FH = 3, SO = 4, BR = 40;
  typedef struct {logic [7:0] f; logic [3:0] c;} sfci_row_t;
  sfci_row_t rows [9];
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd_q = 32'h0;
  logic er_q = 1'h0;
  logic thr = 1'h0;
  logic [1:0] low = 2'h0;
  logic [1:0] chg = 2'h3;
  logic [7:0] flt = 8'h0;
  logic [7:0] r0;
  wire pready, pslverr, drv, brk, tick, lamp;
  wire [31:0] prdata;
  wire [2:0] bar;
  wire [7:0] grp, rises;
  wire [15:0] onl;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  sfci_top #(.POWERUP_CYC(PU), .CHECK_CYC(10), .BRAKE_CYC(BR), .SLOW_HALF(SH), .FAST_HALF(FH),
    .PAUSE(40), .SLEEP_PERIOD(70), .SLEEP_ON(SO)) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .throttle_active(thr), .fault_low_batt_conn(flt[0]), .fault_motor_conn(flt[1]),
    .fault_motor_short(flt[2]), .fault_inhibit(flt[3]), .fault_throttle(flt[4]),
    .fault_internal(flt[5]), .fault_brake_conn(flt[6]), .fault_overvolt(flt[7]),
    .batt_low1(low[0]), .batt_low2(low[1]), .charge_level(chg), .drive_enable_q(drv),
    .brake_engage_q(brk), .check_tick_q(tick), .lamp(lamp), .bar_gauge_display_q(bar));
  sfci_viewer #(.GAP(20)) u_view (.clk(clk), .nrst(nrst), .lamp(lamp), .grp_q(grp),
    .rises_q(rises), .onl_q(onl));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read data taken at the access edge itself, before any register moves
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready) begin
      rd_q <= prdata;
      er_q <= pslverr;
    end
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic start();
    nrst <= 1'h0;
    thr <= 1'h0;
    flt <= 8'h0;
    low <= 2'h0;
    wt(3);
    nrst <= 1'h1;
    wt(1);
  endtask
  initial begin
    rows = '{'{8'h01, `SFCI_CODE_LOWBAT}, '{8'h02, `SFCI_CODE_MOTOR},
      '{8'h04, `SFCI_CODE_SHORT}, '{8'h08, `SFCI_CODE_INHIBIT}, '{8'h10, `SFCI_CODE_THROTTLE},
      '{8'h20, `SFCI_CODE_INTERNAL}, '{8'h40, `SFCI_CODE_BRAKE},
      '{8'h80, `SFCI_CODE_OVERVOLT}, '{8'ha4, `SFCI_CODE_SHORT}};
    foreach (rows[i]) begin
      start();
      apb(1'h1, `SFCI_CTRL_OFF, 32'h1);
      flt <= rows[i].f;
      wt(PU + 10);
      thr <= 1'h1;
      apb(1'h0, `SFCI_TRIP_OFF, 32'h0);
      `CHK(rd_q[8:0], {1'h1, 4'h0, rows[i].c})
      wt(450);
      `CHK({drv, grp}, {1'h0, 4'h0, rows[i].c})
      $display("row %0d done", i);
    end
    start();
    wt(20);
    thr <= 1'h1;
    wt(10);
    thr <= 1'h0;
    wt(PU);
    thr <= 1'h1;
    apb(1'h0, `SFCI_STAT_OFF, 32'h0);
    `CHK({rd_q[11:8], rd_q[2:0]}, {`SFCI_CODE_THROTTLE, 3'h6})
    wt(40);
    `CHK({drv, onl}, {1'h0, 16'(FH)})
    $display("power-up throttle test done");
    start();
    apb(1'h0, `SFCI_CTRL_OFF, 32'h0);
    `CHK(rd_q, `SFCI_CTRL_RST)
    apb(1'h1, 12'h00c, 32'hffff_ffff);
    apb(1'h0, 12'h00c, 32'h0);
    `CHK({er_q, rd_q}, {1'h1, 32'h0})
    wt(PU + 10);
    r0 = rises;
    wt(100);
    `CHK({lamp, rises}, {1'h1, r0})
    for (int k = 0; k < 4; k++) begin
      chg <= k[1:0];
      wt(10);
      `CHK(bar, (k == 0) ? 3'h1 : (k == 1) ? 3'h3 : 3'h7)
    end
    thr <= 1'h1;
    wt(20);
    `CHK({drv, brk}, 2'h2)
    thr <= 1'h0;
    wt(BR - 10);
    `CHK({drv, brk}, 2'h0)
    wt(20);
    `CHK(brk, 1'h1)
    $display("healthy run test done");
    for (int j = 1; j < 3; j++) begin
      start();
      wt(PU + 10);
      low <= j[1:0];
      thr <= 1'h1;
      wt(60);
      `CHK({drv, onl}, {1'h1, 16'(SH)})
    end
    $display("low battery test done");
    start();
    wt(PU + 10);
    apb(1'h1, `SFCI_CTRL_OFF, 32'h2);
    flt <= 8'h20;
    wt(160);
    apb(1'h0, `SFCI_STAT_OFF, 32'h0);
    `CHK({rd_q[3], grp, onl}, {1'h1, 8'h1, 16'(SO)})
    $display("sleep test done");
    start();
    wt(PU + 10);
    thr <= 1'h1;
    wt(10);
    `CHK(drv, 1'h1)
    flt <= 8'h08;
    wt(30);
    flt <= 8'h0;
    wt(30);
    apb(1'h0, `SFCI_TRIP_OFF, 32'h0);
    `CHK({drv, rd_q[8:0]}, {1'h0, 1'h1, 4'h0, `SFCI_CODE_INHIBIT})
    $display("run trip test done");
    print_verdict();
  end
endmodule // sfci_top_tb

// File: testbench/sfci_viewer.sv
// Operator model: counts lamp flashes per group and last on time
`timescale 1ns/1ps
module sfci_viewer #(parameter GAP = 20) (
  input wire clk,
  input wire nrst,
  input wire lamp,
  output logic [7:0] grp_q,
  output logic [7:0] rises_q,
  output logic [15:0] onl_q
);
  logic lamp_q;
  logic [7:0] n_q;
  logic [15:0] on_q;
  logic [15:0] off_q;
  // A dark gap beyond GAP closes a group, so flash gaps must be shorter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lamp_q <= 1'h0;
      n_q <= 8'h0;
      on_q <= 16'h0;
      off_q <= 16'h0;
      grp_q <= 8'h0;
      rises_q <= 8'h0;
      onl_q <= 16'h0;
    end else begin
      lamp_q <= lamp;
      on_q <= lamp ? on_q + 16'h1 : 16'h0;
      off_q <= lamp ? 16'h0 : off_q + 16'h1;
      if (lamp && !lamp_q) begin
        rises_q <= rises_q + 8'h1;
        n_q <= n_q + 8'h1;
      end
      if (!lamp && lamp_q) onl_q <= on_q;
      if (!lamp && off_q == GAP) begin
        grp_q <= n_q;
        n_q <= 8'h0;
      end
    end
  end
endmodule // sfci_viewer
